// *** design/sensor_cfg_pkg.sv ***
package sensor_cfg_pkg;

   // serial frame: 4-bit address then 12-bit data, msb first
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned ADDR_MSB     = 15;
   localparam int unsigned ADDR_LSB     = 12;
   localparam int unsigned DATA_MSB     = 11;

   localparam logic [3:0]  ADDR_ROW_LIMIT   = 4'h2;
   localparam logic [3:0]  ADDR_INTEG       = 4'h3;
   localparam logic [3:0]  ADDR_PULSE_DLY   = 4'h4;
   localparam logic [3:0]  ADDR_COL_START   = 4'h5;
   localparam logic [3:0]  ADDR_ROW_START   = 4'h6;
   localparam logic [3:0]  ADDR_CORE        = 4'h7;
   localparam logic [3:0]  ADDR_AMP         = 4'h8;
   localparam logic [3:0]  ADDR_COARSE      = 4'h9;
   localparam logic [3:0]  ADDR_FINE        = 4'hA;
   localparam logic [3:0]  ADDR_DARK        = 4'hB;
   localparam logic [3:0]  ADDR_CONV        = 4'hC;

   localparam logic [11:0] RST_ROW_LIMIT    = 12'hBC6;
   localparam logic [11:0] RST_INTEG        = 12'h001;
   localparam logic [7:0]  RST_PULSE_DLY    = 8'h03;
   localparam logic [6:0]  RST_COL_START    = 7'h00;
   localparam logic [7:0]  RST_ROW_START    = 8'h00;
   localparam logic [7:0]  RST_CORE         = 8'h00;
   localparam logic [9:0]  RST_AMP          = 10'h010;
   localparam logic [7:0]  RST_DAC          = 8'h80;
   localparam logic [10:0] RST_CONV         = 11'h000;

   localparam logic [11:0] MAX_ROW_LIMIT    = 12'hBC6;
   localparam logic [6:0]  MAX_COL_START    = 7'h62;
   localparam logic [7:0]  MAX_ROW_START    = 8'h89;

   // field positions
   localparam int unsigned CORE_TEST_LSB    = 0;
   localparam int unsigned CORE_COLSKIP_LSB = 2;
   localparam int unsigned CORE_ROWSKIP_LSB = 5;
   localparam int unsigned AMP_GAIN_LSB     = 0;
   localparam int unsigned AMP_UNITY_BIT    = 4;
   localparam int unsigned AMP_ONE_OUT_BIT  = 5;
   localparam int unsigned AMP_STANDBY_BIT  = 6;
   localparam int unsigned AMP_SKEW_LSB     = 7;
   localparam int unsigned CONV_STBY1_BIT   = 0;
   localparam int unsigned CONV_STBY2_BIT   = 1;
   localparam int unsigned CONV_ONE_BIT     = 2;
   localparam int unsigned CONV_SWITCH_BIT  = 3;
   localparam int unsigned CONV_CLKSRC_BIT  = 4;
   localparam int unsigned CONV_TRI_BIT     = 5;
   localparam int unsigned CONV_SKEW_LSB    = 6;
   localparam int unsigned CONV_GAMMA_BIT   = 9;
   localparam int unsigned CONV_FLIP_BIT    = 10;

   localparam int unsigned DELAY_DEPTH      = 15;
   localparam logic [3:0]  UNITY_GAIN_CODE  = 4'h0;

   typedef struct packed
   {
      logic [3:0] gain_code;
      logic       unity;
      logic       one_output;
      logic       standby;
      logic [2:0] amp_clock_skew;
   } amp_ctrl_s;

   typedef struct packed
   {
      logic       standby_1;
      logic       standby_2;
      logic       mux_off;
      logic       switch_sel;
      logic       converter_clock_source;
      logic       tristate;
      logic [2:0] conv_clock_skew;
      logic       gamma;
      logic       bit_flip;
   } conv_ctrl_s;

   typedef struct packed
   {
      logic [1:0] test_mode;
      logic [2:0] column_skip_mode;
      logic [2:0] row_skip_mode;
   } core_ctrl_s;

endpackage

// *** design/sensor_cfg_upper.sv ***
`timescale 1ns/1ps
// Operation
// - 12-bit row count limit, writes above 3014 saturate to 3014.
// - count row clocks after frame start, pulse frame end at the limit.
// - 12-bit integration time, resets to one, fed to the sequencer.
// - low nibble delays pixel valid, high nibble delays line/frame end.
// - 7-bit column window start, legal 0 to 98.
// - 8-bit row window start, legal 0 to 137.
// - two-bit test mode, low bit odd columns, high bit even columns.
// - column skip mode at bits 4:2, row skip mode at bits 7:5.
// - gain code applied unless unity bit 4 set, then unity gain.
// - amplifier bit 5 merges both streams onto the first output.
// - amplifier bit 6 puts the output amplifier into standby.
// - amplifier bits 9:7 choose the amplifier pixel clock skew.
// - coarse and fine offset codes, 8 bits, reset to 0x80.
// - 8-bit dark reference code, reset to midscale.
// - converter bit 2 low multiplexes both converters onto the output.
// - bit 3 delays the muxed stream when bit 4 is low, or picks a converter when unmuxed.
// - converter bit 4 selects internal or external converter clock.
// - converter bit 5 puts the pixel outputs into high impedance.
// - converter bits 8:6 choose the converter clock skew.
// - converter bit 9 selects gamma-law instead of linear conversion.
// - converter bit 10 inverts every bit of the output word.
module sensor_cfg_upper
(
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic                      link_clock,
   input  wire logic                      link_data,
   input  wire logic                      link_load,
   input  wire logic                      frame_start,
   input  wire logic                      row_clock,
   input  wire logic                      pixel_valid_raw,
   input  wire logic                      line_end_raw,
   input  wire logic [9:0]                conv_a_word,
   input  wire logic [9:0]                conv_b_word,
   output logic [11:0]                    row_count_limit_reg,
   output logic [11:0]                    integration_rows_reg,
   output logic [6:0]                     column_window_start_reg,
   output logic [7:0]                     row_window_start_reg,
   output sensor_cfg_pkg::core_ctrl_s     core_ctrl,
   output sensor_cfg_pkg::amp_ctrl_s      amp_ctrl,
   output sensor_cfg_pkg::conv_ctrl_s     conv_ctrl,
   output logic [7:0]                     coarse_offset_dac,
   output logic [7:0]                     fine_offset_dac,
   output logic [7:0]                     dark_level_dac,
   output logic [11:0]                    line_count,
   output logic                           pixel_valid_flag,
   output logic                           line_end_pulse,
   output logic                           frame_end_pulse,
   output logic [9:0]                     pixel_out,
   output logic                           pixel_out_oe
);

   logic [1:0]  rst_sync;
   logic        rst_n;
   logic [7:0]  pulse_delay_reg;
   logic [7:0]  array_core_config;
   logic [9:0]  output_amp_config;
   logic [10:0] converter_config;

   ////////////////////////////////////////////////////////////////////////
   // reset release

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   assign rst_n = rst_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 0 feeds only stage 1

   logic [1:0] sclk_sync;
   logic [1:0] sdat_sync;
   logic [1:0] sload_sync;
   logic [1:0] fstart_sync;
   logic [1:0] rowclk_sync;
   logic       sclk_prev;
   logic       sload_prev;
   logic       fstart_prev;
   logic       rowclk_prev;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_sync   <= 2'h0;
         sdat_sync   <= 2'h0;
         sload_sync  <= 2'h0;
         fstart_sync <= 2'h0;
         rowclk_sync <= 2'h0;
         sclk_prev   <= 1'b0;
         sload_prev  <= 1'b0;
         fstart_prev <= 1'b0;
         rowclk_prev <= 1'b0;
      end
      else
      begin
         sclk_sync   <= {sclk_sync[0], link_clock};
         sdat_sync   <= {sdat_sync[0], link_data};
         sload_sync  <= {sload_sync[0], link_load};
         fstart_sync <= {fstart_sync[0], frame_start};
         rowclk_sync <= {rowclk_sync[0], row_clock};
         sclk_prev   <= sclk_sync[1];
         sload_prev  <= sload_sync[1];
         fstart_prev <= fstart_sync[1];
         rowclk_prev <= rowclk_sync[1];
      end
   end

   logic sclk_rise;
   logic sload_rise;
   logic fstart_rise;
   logic rowclk_rise;

   assign sclk_rise   = sclk_sync[1] & ~sclk_prev;
   assign sload_rise  = sload_sync[1] & ~sload_prev;
   assign fstart_rise = fstart_sync[1] & ~fstart_prev;
   assign rowclk_rise = rowclk_sync[1] & ~rowclk_prev;

   ////////////////////////////////////////////////////////////////////////
   // serial shifter; data is stable around the link clock rising edge

   logic [sensor_cfg_pkg::FRAME_BITS-1:0] shift_word;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         shift_word <= 16'h0000;
      else if (sclk_rise)
         shift_word <= {shift_word[sensor_cfg_pkg::FRAME_BITS-2:0], sdat_sync[1]};
   end

   logic [3:0]  wr_addr;
   logic [11:0] wr_data;
   logic        wr_en;

   assign wr_addr = shift_word[sensor_cfg_pkg::ADDR_MSB:sensor_cfg_pkg::ADDR_LSB];
   assign wr_data = shift_word[sensor_cfg_pkg::DATA_MSB:0];
   assign wr_en   = sload_rise;

   ////////////////////////////////////////////////////////////////////////
   // register bank; 0, 1 live elsewhere, 13..15 fall through untouched

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_count_limit_reg     <= sensor_cfg_pkg::RST_ROW_LIMIT;
         integration_rows_reg    <= sensor_cfg_pkg::RST_INTEG;
         pulse_delay_reg         <= sensor_cfg_pkg::RST_PULSE_DLY;
         column_window_start_reg <= sensor_cfg_pkg::RST_COL_START;
         row_window_start_reg    <= sensor_cfg_pkg::RST_ROW_START;
         array_core_config       <= sensor_cfg_pkg::RST_CORE;
         output_amp_config       <= sensor_cfg_pkg::RST_AMP;
         coarse_offset_dac       <= sensor_cfg_pkg::RST_DAC;
         fine_offset_dac         <= sensor_cfg_pkg::RST_DAC;
         dark_level_dac          <= sensor_cfg_pkg::RST_DAC;
         converter_config        <= sensor_cfg_pkg::RST_CONV;
      end
      else if (wr_en)
      begin
         unique case (wr_addr)
            sensor_cfg_pkg::ADDR_ROW_LIMIT:
               // out-of-range limits saturate rather than wrap
               row_count_limit_reg <= (wr_data > sensor_cfg_pkg::MAX_ROW_LIMIT) ?
                                      sensor_cfg_pkg::MAX_ROW_LIMIT : wr_data;
            sensor_cfg_pkg::ADDR_INTEG:
               integration_rows_reg <= wr_data;
            sensor_cfg_pkg::ADDR_PULSE_DLY:
               pulse_delay_reg <= wr_data[7:0];
            sensor_cfg_pkg::ADDR_COL_START:
               column_window_start_reg <= (wr_data[6:0] > sensor_cfg_pkg::MAX_COL_START) ?
                                          sensor_cfg_pkg::MAX_COL_START : wr_data[6:0];
            sensor_cfg_pkg::ADDR_ROW_START:
               row_window_start_reg <= (wr_data[7:0] > sensor_cfg_pkg::MAX_ROW_START) ?
                                       sensor_cfg_pkg::MAX_ROW_START : wr_data[7:0];
            sensor_cfg_pkg::ADDR_CORE:
               array_core_config <= wr_data[7:0];
            sensor_cfg_pkg::ADDR_AMP:
               output_amp_config <= wr_data[9:0];
            sensor_cfg_pkg::ADDR_COARSE:
               coarse_offset_dac <= wr_data[7:0];
            sensor_cfg_pkg::ADDR_FINE:
               fine_offset_dac <= wr_data[7:0];
            sensor_cfg_pkg::ADDR_DARK:
               dark_level_dac <= wr_data[7:0];
            sensor_cfg_pkg::ADDR_CONV:
               converter_config <= wr_data[10:0];
            default:
               ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field decode

   always_comb
   begin
      core_ctrl.test_mode        = array_core_config[sensor_cfg_pkg::CORE_TEST_LSB +: 2];
      core_ctrl.column_skip_mode = array_core_config[sensor_cfg_pkg::CORE_COLSKIP_LSB +: 3];
      core_ctrl.row_skip_mode    = array_core_config[sensor_cfg_pkg::CORE_ROWSKIP_LSB +: 3];

      amp_ctrl.unity          = output_amp_config[sensor_cfg_pkg::AMP_UNITY_BIT];
      amp_ctrl.gain_code      = amp_ctrl.unity ? sensor_cfg_pkg::UNITY_GAIN_CODE :
                                output_amp_config[sensor_cfg_pkg::AMP_GAIN_LSB +: 4];
      amp_ctrl.one_output     = output_amp_config[sensor_cfg_pkg::AMP_ONE_OUT_BIT];
      amp_ctrl.standby        = output_amp_config[sensor_cfg_pkg::AMP_STANDBY_BIT];
      amp_ctrl.amp_clock_skew = output_amp_config[sensor_cfg_pkg::AMP_SKEW_LSB +: 3];

      conv_ctrl.standby_1              = converter_config[sensor_cfg_pkg::CONV_STBY1_BIT];
      conv_ctrl.standby_2              = converter_config[sensor_cfg_pkg::CONV_STBY2_BIT];
      conv_ctrl.mux_off                = converter_config[sensor_cfg_pkg::CONV_ONE_BIT];
      conv_ctrl.switch_sel             = converter_config[sensor_cfg_pkg::CONV_SWITCH_BIT];
      conv_ctrl.converter_clock_source = converter_config[sensor_cfg_pkg::CONV_CLKSRC_BIT];
      conv_ctrl.tristate               = converter_config[sensor_cfg_pkg::CONV_TRI_BIT];
      conv_ctrl.conv_clock_skew        = converter_config[sensor_cfg_pkg::CONV_SKEW_LSB +: 3];
      conv_ctrl.gamma                  = converter_config[sensor_cfg_pkg::CONV_GAMMA_BIT];
      conv_ctrl.bit_flip               = converter_config[sensor_cfg_pkg::CONV_FLIP_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // line counter

   logic frame_active;
   logic frame_end_raw;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_count    <= 12'h000;
         frame_active  <= 1'b0;
         frame_end_raw <= 1'b0;
      end
      else
      begin
         frame_end_raw <= 1'b0;
         if (fstart_rise)
         begin
            line_count   <= 12'h000;
            frame_active <= 1'b1;
         end
         else if (rowclk_rise && frame_active)
         begin
            line_count <= line_count + 12'h001;
            if (line_count + 12'h001 == row_count_limit_reg)
            begin
               frame_end_raw <= 1'b1;
               frame_active  <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // programmable pulse delays; tap 0 is the undelayed signal

   logic [sensor_cfg_pkg::DELAY_DEPTH-1:0] valid_line;
   logic [sensor_cfg_pkg::DELAY_DEPTH-1:0] eol_line;
   logic [sensor_cfg_pkg::DELAY_DEPTH-1:0] eof_line;
   logic [3:0]                             valid_pulse_delay;
   logic [3:0]                             end_marker_delay;

   assign valid_pulse_delay = pulse_delay_reg[3:0];
   assign end_marker_delay  = pulse_delay_reg[7:4];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         valid_line <= '0;
         eol_line   <= '0;
         eof_line   <= '0;
      end
      else
      begin
         valid_line <= {valid_line[sensor_cfg_pkg::DELAY_DEPTH-2:0], pixel_valid_raw};
         eol_line   <= {eol_line[sensor_cfg_pkg::DELAY_DEPTH-2:0], line_end_raw};
         eof_line   <= {eof_line[sensor_cfg_pkg::DELAY_DEPTH-2:0], frame_end_raw};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pixel_valid_flag <= 1'b0;
         line_end_pulse   <= 1'b0;
         frame_end_pulse  <= 1'b0;
      end
      else
      begin
         pixel_valid_flag <= (valid_pulse_delay == 4'h0) ? pixel_valid_raw :
                             valid_line[valid_pulse_delay - 4'h1];
         line_end_pulse   <= (end_marker_delay == 4'h0) ? line_end_raw :
                             eol_line[end_marker_delay - 4'h1];
         frame_end_pulse  <= (end_marker_delay == 4'h0) ? frame_end_raw :
                             eof_line[end_marker_delay - 4'h1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // converter output path

   logic       mux_phase;
   logic [9:0] muxed_word;
   logic [9:0] held_word;
   logic [9:0] pick_word;
   logic [9:0] curve_word;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mux_phase <= 1'b0;
         held_word <= 10'h000;
      end
      else
      begin
         mux_phase <= ~mux_phase;
         held_word <= muxed_word;
      end
   end

   // external-clock half-cycle shift cannot exist on one clock; only the
   // internal-clock full-cycle delay is applied here
   always_comb
   begin
      if (conv_ctrl.mux_off)
         muxed_word = conv_ctrl.switch_sel ? conv_b_word : conv_a_word;
      else
         muxed_word = mux_phase ? conv_b_word : conv_a_word;
      if (!conv_ctrl.mux_off && conv_ctrl.switch_sel && !conv_ctrl.converter_clock_source)
         pick_word = held_word;
      else
         pick_word = muxed_word;
   end

   // piecewise square-root-like curve: steep low end, compressed top
   always_comb
   begin
      if (!conv_ctrl.gamma)
         curve_word = pick_word;
      else if (pick_word < 10'h080)
         curve_word = {pick_word[7:0], 2'h0};
      else
         curve_word = 10'h180 + {1'b0, pick_word[9:1]} - 10'h040;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pixel_out    <= 10'h000;
         pixel_out_oe <= 1'b0;
      end
      else
      begin
         pixel_out    <= conv_ctrl.bit_flip ? ~curve_word : curve_word;
         pixel_out_oe <= ~conv_ctrl.tristate;
      end
   end

endmodule

// *** tb/link_ctrl_model.sv ***
`timescale 1ns/1ps
module link_ctrl_model
(
   output logic link_clock,
   output logic link_data,
   output logic link_load
);
   initial {link_clock, link_data, link_load} = 3'h0;
   // clock idles low between frames; 200 ns period
   task automatic send(input logic [3:0] addr, input logic [11:0] data);
      logic [15:0] word;
      word = {addr, data};
      for (int i = 15; i >= 0; i--)
      begin
         link_data = word[i];
         #100 link_clock = 1'b1;
         #100 link_clock = 1'b0;
      end
      #100 link_load = 1'b1;
      #200 link_load = 1'b0;
      // line not held after the frame: show the opposite level
      link_data = ~link_data;
      #100;
   endtask
endmodule

// *** tb/sensor_cfg_upper_asserts.sv ***
`timescale 1ns/1ps
module sensor_cfg_upper_asserts
(
   input wire logic                       clk,
   input wire logic                       resetn,
   input wire logic                       link_load,
   input wire logic                       pixel_valid_raw,
   input wire logic                       line_end_raw,
   input wire logic [9:0]                 conv_a_word,
   input wire logic [9:0]                 conv_b_word,
   input wire logic [11:0]                row_count_limit_reg,
   input wire logic [11:0]                integration_rows_reg,
   input wire logic [6:0]                 column_window_start_reg,
   input wire logic [7:0]                 row_window_start_reg,
   input wire sensor_cfg_pkg::core_ctrl_s core_ctrl,
   input wire sensor_cfg_pkg::amp_ctrl_s  amp_ctrl,
   input wire sensor_cfg_pkg::conv_ctrl_s conv_ctrl,
   input wire logic [7:0]                 coarse_offset_dac,
   input wire logic [7:0]                 fine_offset_dac,
   input wire logic [7:0]                 dark_level_dac,
   input wire logic [11:0]                line_count,
   input wire logic                       pixel_valid_flag,
   input wire logic                       line_end_pulse,
   input wire logic                       frame_end_pulse,
   input wire logic [9:0]                 pixel_out,
   input wire logic                       pixel_out_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // a commit lands within 4 clk of the load rise, so 8 quiet cycles mean settled
   sequence s_quiet;
      (!link_load) [*8];
   endsequence
   sequence s_pick_no_gamma;
      $past(conv_ctrl.mux_off && !conv_ctrl.gamma);
   endsequence
   property p_quiet;
      s_quiet |-> $stable({row_count_limit_reg, integration_rows_reg, column_window_start_reg,
         row_window_start_reg, core_ctrl, amp_ctrl, conv_ctrl, coarse_offset_dac,
         fine_offset_dac, dark_level_dac});
   endproperty
   property p_unity;
      amp_ctrl.unity |-> amp_ctrl.gain_code == 4'h0;
   endproperty
   property p_tri;
      conv_ctrl.tristate |=> !pixel_out_oe;
   endproperty
   property p_pick;
      s_pick_no_gamma |-> pixel_out == ($past(conv_ctrl.bit_flip) ?
         ~($past(conv_ctrl.switch_sel) ? $past(conv_b_word) : $past(conv_a_word)) :
         ($past(conv_ctrl.switch_sel) ? $past(conv_b_word) : $past(conv_a_word)));
   endproperty
   property p_eol;
      $rose(line_end_raw) |-> ##[1:16] line_end_pulse;
   endproperty
   property p_pv;
      $rose(pixel_valid_raw) |-> ##[1:16] $rose(pixel_valid_flag);
   endproperty
   property p_range;
      row_count_limit_reg <= 12'hBC6 && column_window_start_reg <= 7'h62
         && row_window_start_reg <= 8'h89;
   endproperty
   property p_fend;
      frame_end_pulse |-> line_count == row_count_limit_reg ##1 !frame_end_pulse;
   endproperty
   property p_step;
      $changed(line_count) |-> line_count == $past(line_count) + 12'h001
         || line_count == 12'h000;
   endproperty
   a_quiet: assert property (p_quiet) else $error("register moved without a load");
   a_unity: assert property (p_unity) else $error("gain code shown under unity");
   a_tri: assert property (p_tri) else $error("pixel outputs driven in tristate");
   a_pick: assert property (p_pick) else $error("wrong converter word");
   a_eol: assert property (p_eol) else $error("line end pulse missing");
   a_pv: assert property (p_pv) else $error("pixel valid missing");
   a_range: assert property (p_range) else $error("position above limit");
   a_fend: assert property (p_fend) else $error("bad frame end pulse");
   a_step: assert property (p_step) else $error("line count jumped");
endmodule
bind sensor_cfg_upper sensor_cfg_upper_asserts chk
(
   .clk(clk), .resetn(resetn), .link_load(link_load), .pixel_valid_raw(pixel_valid_raw),
   .line_end_raw(line_end_raw), .conv_a_word(conv_a_word), .conv_b_word(conv_b_word),
   .row_count_limit_reg(row_count_limit_reg), .integration_rows_reg(integration_rows_reg),
   .column_window_start_reg(column_window_start_reg), .core_ctrl(core_ctrl),
   .row_window_start_reg(row_window_start_reg), .amp_ctrl(amp_ctrl), .conv_ctrl(conv_ctrl),
   .coarse_offset_dac(coarse_offset_dac), .fine_offset_dac(fine_offset_dac),
   .dark_level_dac(dark_level_dac), .line_count(line_count), .pixel_out(pixel_out),
   .pixel_valid_flag(pixel_valid_flag), .line_end_pulse(line_end_pulse),
   .frame_end_pulse(frame_end_pulse), .pixel_out_oe(pixel_out_oe)
);

// *** tb/sensor_cfg_upper_test.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module sensor_cfg_upper_test;
   logic clk = 1'b0, resetn = 1'b0, frame_start = 1'b0, row_clock = 1'b0;
   logic pixel_valid_raw = 1'b0, line_end_raw = 1'b0;
   logic link_clock, link_data, link_load, pixel_valid_flag, line_end_pulse;
   logic frame_end_pulse, pixel_out_oe, ph = 1'b0, pq;
   logic [9:0] conv_a_word = 10'h010, conv_b_word = 10'h200, pixel_out, p1, p2;
   logic [11:0] row_count_limit_reg, integration_rows_reg, line_count;
   logic [6:0] column_window_start_reg;
   logic [7:0] row_window_start_reg, coarse_offset_dac, fine_offset_dac, dark_level_dac;
   sensor_cfg_pkg::core_ctrl_s core_ctrl;
   sensor_cfg_pkg::amp_ctrl_s amp_ctrl;
   sensor_cfg_pkg::conv_ctrl_s conv_ctrl;
   int bad_count = 0, checks_done = 0, fe_count = 0;
   logic [11:0] shadow [2:12] = '{12'hBC6, 12'h001, 12'h003, 12'h000, 12'h000, 12'h000,
      12'h010, 12'h080, 12'h080, 12'h080, 12'h000};
   logic [15:0] wr [20] = '{16'h2123, 16'h2FFF, 16'h3ABC, 16'h5062, 16'h507F, 16'h6089,
      16'h60FF, 16'h70E5, 16'h83AF, 16'h8355, 16'h9012, 16'hA0FE, 16'hB000, 16'hC555,
      16'hCAAA, 16'hD000, 16'hEFFF, 16'hF123, 16'h1555, 16'h2005};
   logic [11:0] pc [6] = '{12'h004, 12'h00C, 12'h404, 12'h204, 12'h20C, 12'h60C};
   logic [9:0] pe [6] = '{10'h010, 10'h200, 10'h3EF, 10'h040, 10'h240, 10'h1BF};
   logic [11:0] dl [3] = '{12'h003, 12'h052, 12'h0F0};
   int ev [3] = '{4, 3, 1};
   int ee [3] = '{1, 6, 16};
   always #12.5 clk = ~clk;
   always @(posedge clk) if (frame_end_pulse === 1'b1) fe_count <= fe_count + 1;
   // free toggle in step with the converter mux phase, to line up delayed words
   always @(posedge clk) ph <= ~ph;
   sensor_cfg_upper dut
   (
      .clk(clk), .resetn(resetn), .link_clock(link_clock), .link_data(link_data),
      .link_load(link_load), .frame_start(frame_start), .row_clock(row_clock),
      .pixel_valid_raw(pixel_valid_raw), .line_end_raw(line_end_raw),
      .conv_a_word(conv_a_word), .conv_b_word(conv_b_word),
      .row_count_limit_reg(row_count_limit_reg), .integration_rows_reg(integration_rows_reg),
      .column_window_start_reg(column_window_start_reg), .core_ctrl(core_ctrl),
      .row_window_start_reg(row_window_start_reg), .amp_ctrl(amp_ctrl), .conv_ctrl(conv_ctrl),
      .coarse_offset_dac(coarse_offset_dac), .fine_offset_dac(fine_offset_dac),
      .dark_level_dac(dark_level_dac), .line_count(line_count), .pixel_out(pixel_out),
      .pixel_valid_flag(pixel_valid_flag), .line_end_pulse(line_end_pulse),
      .frame_end_pulse(frame_end_pulse), .pixel_out_oe(pixel_out_oe)
   );
   link_ctrl_model link
   (
      .link_clock(link_clock),
      .link_data(link_data),
      .link_load(link_load)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [11:0] d);
      link.send(a, d);
      repeat (4) @(negedge clk);
      case (a)
         4'h2: shadow[2] = (d > 12'hBC6) ? 12'hBC6 : d;
         4'h5: shadow[5] = (d > 12'h062) ? 12'h062 : d;
         4'h6: shadow[6] = (d > 12'h089) ? 12'h089 : d;
         4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC: shadow[a] = d;
         default: ;
      endcase
   endtask
   task automatic check_regs();
      logic [11:0] a = shadow[8], c = shadow[12];
      `CHK(row_count_limit_reg, shadow[2])
      `CHK(integration_rows_reg, shadow[3])
      `CHK(column_window_start_reg, shadow[5][6:0])
      `CHK(row_window_start_reg, shadow[6][7:0])
      `CHK(core_ctrl, ({shadow[7][1:0], shadow[7][4:2], shadow[7][7:5]}))
      `CHK(amp_ctrl, ({a[4] ? 4'h0 : a[3:0], a[4], a[5], a[6], a[9:7]}))
      `CHK(conv_ctrl, ({c[0], c[1], c[2], c[3], c[4], c[5], c[8:6], c[9], c[10]}))
      `CHK(coarse_offset_dac, shadow[9][7:0])
      `CHK(fine_offset_dac, shadow[10][7:0])
      `CHK(dark_level_dac, shadow[11][7:0])
   endtask
   task automatic pin_pulse(ref logic pin);
      @(negedge clk) pin = 1'b1;
      repeat (4) @(negedge clk);
      pin = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // cycles from raw input to delayed output, seen at falling edges
   task automatic measure(input int exp_v, input int exp_e);
      int nv = 0, ne = 0;
      @(negedge clk);
      pixel_valid_raw = 1'b1;
      line_end_raw = 1'b1;
      for (int n = 1; n <= 20; n++)
      begin
         @(negedge clk);
         line_end_raw = 1'b0;
         if (pixel_valid_flag === 1'b1 && nv == 0) nv = n;
         if (line_end_pulse === 1'b1 && ne == 0) ne = n;
      end
      pixel_valid_raw = 1'b0;
      repeat (20) @(negedge clk);
      `CHK(nv, exp_v)
      `CHK(ne, exp_e)
   endtask
   initial
   begin
      #2000000;
      bad_count++;
      finish_test();
   end
   initial
   begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      check_regs();
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0) reg_write(4'h4, dl[i]);
         measure(ev[i], ee[i]);
      end
      foreach (wr[i])
      begin
         reg_write(wr[i][15:12], wr[i][11:0]);
         check_regs();
      end
      pin_pulse(row_clock);
      `CHK(line_count, 12'h000)
      pin_pulse(frame_start);
      repeat (4) pin_pulse(row_clock);
      repeat (40) @(negedge clk);
      `CHK(fe_count, 0)
      `CHK(line_count, 12'h004)
      repeat (2) pin_pulse(row_clock);
      repeat (40) @(negedge clk);
      `CHK(fe_count, 1)
      `CHK(line_count, 12'h005)
      foreach (pc[i])
      begin
         reg_write(4'hC, pc[i]);
         `CHK(pixel_out, pe[i])
         `CHK(pixel_out_oe, 1'b1)
      end
      reg_write(4'hC, 12'h000);
      p1 = pixel_out;
      @(negedge clk);
      p2 = pixel_out;
      pq = ph;
      `CHK((p1 === 10'h010 && p2 === 10'h200) || (p1 === 10'h200 && p2 === 10'h010), 1'b1)
      // muxed stream with one-clock delay shows the other word at the same phase
      reg_write(4'hC, 12'h008);
      if (ph !== pq) @(negedge clk);
      `CHK(pixel_out, p2 ^ 10'h210)
      reg_write(4'hC, 12'h020);
      `CHK(pixel_out_oe, 1'b0)
      finish_test();
   end
endmodule
